// ### cfg_bank.v
`include "sop_defines.vh"

// ****************************************************************
// configuration byte store, flat view plus registered read port
// ****************************************************************
module cfg_bank #(
  parameter DEPTH = `BANK_DEPTH
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             wr_en,
  input  wire [3:0]       wr_index,
  input  wire [7:0]       wr_data,
  input  wire             rd_en,
  input  wire             rd_hit,
  input  wire [3:0]       rd_index,
  output reg  [7:0]       rd_data,
  output wire [DEPTH*8-1:0] bytes_flat
);

  reg [7:0] mem_reg [0:DEPTH-1];
  integer   i;

  // flat view so the product logic sees every byte at once
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : flat
      assign bytes_flat[g*8 +: 8] = mem_reg[g];
    end
  endgenerate

  // writes and reads; unmapped reads return zero
  always @(posedge clk) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= `CFG_RESET;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem_reg[wr_index] <= wr_data;
      end
      if (rd_en) begin
        rd_data <= rd_hit ? mem_reg[rd_index] : 8'h00;
      end
    end
  end

endmodule

// ### seq_output_sum_of_products.v
`include "sop_defines.vh"

// Operation
// - each output deasserts when product 1 or product 2 is one
// - primary byte: bits 0-5 detector primary flags, bits 6-7 watchdogs 1-2
// - secondary byte: bits 0-5 detector secondary flags, bits 6-7 logic inputs 1-2
// - A output byte: logic inputs 3-4, outputs 1-2, 4-7; shared bit 0 output 8
// - A product 2 same layout, output 8 via shared byte bit 1
// - B product 1: bit 4 selects output A, bits 5-7 outputs 5-7
// - manual reset byte bit 2 forces A, bit 3 forces B while low
// - product is one only when every selected condition is healthy
// - B product 2 same layout, output 8 via shared byte bit 1
module seq_output_sum_of_products (
  input  wire       clk,
  input  wire       nrst,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  input  wire [7:0] cfg_addr,
  input  wire [7:0] cfg_wdata,
  output wire [7:0] cfg_rdata,
  input  wire [5:0] volt_primary_ok,
  input  wire [5:0] volt_secondary_ok,
  input  wire       watchdog_timer_1,
  input  wire       watchdog_timer_2,
  input  wire       logic_input_1,
  input  wire       logic_input_2,
  input  wire       logic_input_3,
  input  wire       logic_input_4,
  input  wire       seq_out_1,
  input  wire       seq_out_2,
  input  wire       seq_out_5,
  input  wire       seq_out_6,
  input  wire       seq_out_7,
  input  wire       seq_out_8,
  input  wire       manual_reset_n,
  output reg        seq_out_3,
  output reg        seq_out_4,
  output reg  [1:0] out_a_products,
  output reg  [1:0] out_b_products
);

  // ****************************************************************
  // offset to bank row, shared by the port and the product logic
  // ****************************************************************
  // the reset byte lies far past the run, so it takes the spare last row
  function [3:0] bank_row;
    input [7:0] ofs;
    reg   [7:0] rel;
    begin
      rel = ofs - `BANK_FIRST;
      if (ofs == `OFS_MR_DEPEND) begin
        bank_row = `BANK_MR_INDEX;
      end else begin
        bank_row = rel[3:0];
      end
    end
  endfunction

  // ****************************************************************
  // address decode into the byte bank
  // ****************************************************************
  wire       in_range;
  wire       is_mr;
  wire       hit;
  wire [3:0] bank_index;
  wire [`BANK_DEPTH*8-1:0] cfg_flat;

  // bank rows 0..13 follow the offsets, row 14 holds the reset byte
  assign in_range   = (cfg_addr >= `BANK_FIRST) && (cfg_addr <= `BANK_LAST);
  assign is_mr      = (cfg_addr == `OFS_MR_DEPEND);
  assign hit        = in_range | is_mr;
  assign bank_index = bank_row(cfg_addr);

  cfg_bank #(
    .DEPTH(`BANK_DEPTH)
  ) u_bank (
    .clk       (clk),
    .nrst      (nrst),
    .wr_en     (cfg_wr & hit),
    .wr_index  (bank_index),
    .wr_data   (cfg_wdata),
    .rd_en     (cfg_rd),
    .rd_hit    (hit),
    .rd_index  (bank_index),
    .rd_data   (cfg_rdata),
    .bytes_flat(cfg_flat)
  );

  // ****************************************************************
  // byte extraction
  // ****************************************************************
  function [7:0] cfg_byte;
    input [`BANK_DEPTH*8-1:0] flat;
    input [7:0]               ofs;
    begin
      cfg_byte = flat[bank_row(ofs)*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // product term: AND of healthy flags over selected bits
  // ****************************************************************
  function product;
    input [7:0] prim_sel;
    input [7:0] sec_sel;
    input [7:0] out_sel;
    input       eighth_sel;
    input [7:0] prim_ok;
    input [7:0] sec_ok;
    input [7:0] out_ok;
    input       eighth_ok;
    begin
      // unselected bits count as healthy, so they drop out
      product = &(~prim_sel | prim_ok) & &(~sec_sel | sec_ok) &
                &(~out_sel | out_ok) & (~eighth_sel | eighth_ok);
    end
  endfunction

  // ****************************************************************
  // healthy vectors, one bit per selection bit
  // ****************************************************************
  wire [7:0] prim_ok;
  wire [7:0] sec_ok;
  wire [7:0] a_out_ok;
  wire [7:0] b_out_ok;

  // watchdog expired and logic input active both count as unhealthy
  assign prim_ok  = {~watchdog_timer_2, ~watchdog_timer_1, volt_primary_ok};
  assign sec_ok   = {~logic_input_2, ~logic_input_1, volt_secondary_ok};
  // A sees outputs 1,2,4..7; B sees 1,2,A,5..7
  assign a_out_ok = {~seq_out_7, ~seq_out_6, ~seq_out_5, ~seq_out_4,
                     ~seq_out_2, ~seq_out_1, ~logic_input_4, ~logic_input_3};
  assign b_out_ok = {~seq_out_7, ~seq_out_6, ~seq_out_5, ~seq_out_3,
                     ~seq_out_2, ~seq_out_1, ~logic_input_4, ~logic_input_3};

  // ****************************************************************
  // product evaluation
  // ****************************************************************
  wire [7:0] a_p1_prim;
  wire [7:0] a_p1_sec;
  wire [7:0] a_p1_out;
  wire [7:0] a_p2_prim;
  wire [7:0] a_p2_sec;
  wire [7:0] a_p2_out;
  wire [7:0] b_p1_prim;
  wire [7:0] b_p1_sec;
  wire [7:0] b_p1_out;
  wire [7:0] b_p2_prim;
  wire [7:0] b_p2_sec;
  wire [7:0] b_p2_out;
  wire [7:0] a_eighth;
  wire [7:0] b_eighth;
  wire [7:0] mr_dep;
  wire       a_p1;
  wire       a_p2;
  wire       b_p1;
  wire       b_p2;
  wire       mr_low;

  // selection bytes pulled out once, so each product call reads plainly
  assign a_p1_prim = cfg_byte(cfg_flat, `OFS_A_P1_PRIMARY);
  assign a_p1_sec  = cfg_byte(cfg_flat, `OFS_A_P1_SECONDARY);
  assign a_p1_out  = cfg_byte(cfg_flat, `OFS_A_P1_OUTPUT);
  assign a_p2_prim = cfg_byte(cfg_flat, `OFS_A_P2_PRIMARY);
  assign a_p2_sec  = cfg_byte(cfg_flat, `OFS_A_P2_SECONDARY);
  assign a_p2_out  = cfg_byte(cfg_flat, `OFS_A_P2_OUTPUT);
  assign b_p1_prim = cfg_byte(cfg_flat, `OFS_B_P1_PRIMARY);
  assign b_p1_sec  = cfg_byte(cfg_flat, `OFS_B_P1_SECONDARY);
  assign b_p1_out  = cfg_byte(cfg_flat, `OFS_B_P1_OUTPUT);
  assign b_p2_prim = cfg_byte(cfg_flat, `OFS_B_P2_PRIMARY);
  assign b_p2_sec  = cfg_byte(cfg_flat, `OFS_B_P2_SECONDARY);
  assign b_p2_out  = cfg_byte(cfg_flat, `OFS_B_P2_OUTPUT);
  assign a_eighth  = cfg_byte(cfg_flat, `OFS_A_EIGHTH);
  assign b_eighth  = cfg_byte(cfg_flat, `OFS_B_EIGHTH);
  assign mr_dep    = cfg_byte(cfg_flat, `OFS_MR_DEPEND);
  assign mr_low    = ~manual_reset_n;

  // A product 1, output 8 from shared byte bit 0
  assign a_p1 = product(a_p1_prim,
                        a_p1_sec,
                        a_p1_out,
                        a_eighth[`BIT_P1_EIGHTH],
                        prim_ok, sec_ok, a_out_ok, ~seq_out_8);
  // A product 2, output 8 from shared byte bit 1
  assign a_p2 = product(a_p2_prim,
                        a_p2_sec,
                        a_p2_out,
                        a_eighth[`BIT_P2_EIGHTH],
                        prim_ok, sec_ok, a_out_ok, ~seq_out_8);
  // B product 1, output 8 from its own shared byte bit 0
  assign b_p1 = product(b_p1_prim,
                        b_p1_sec,
                        b_p1_out,
                        b_eighth[`BIT_P1_EIGHTH],
                        prim_ok, sec_ok, b_out_ok, ~seq_out_8);
  // B product 2, output 8 from shared byte bit 1
  assign b_p2 = product(b_p2_prim,
                        b_p2_sec,
                        b_p2_out,
                        b_eighth[`BIT_P2_EIGHTH],
                        prim_ok, sec_ok, b_out_ok, ~seq_out_8);

  // ****************************************************************
  // output state, one register stage per cycle
  // ****************************************************************
  // registered so the A/B cross-dependency never forms a comb loop
  always @(posedge clk) begin
    if (!nrst) begin
      seq_out_3      <= 1'b0;
      seq_out_4      <= 1'b0;
      out_a_products <= 2'b00;
      out_b_products <= 2'b00;
    end else begin
      out_a_products <= {a_p2, a_p1};
      out_b_products <= {b_p2, b_p1};
      // asserted unless a product holds, or forced by manual reset
      seq_out_3 <= ~(a_p1 | a_p2) | (mr_dep[`BIT_MR_OUT_A] & mr_low);
      seq_out_4 <= ~(b_p1 | b_p2) | (mr_dep[`BIT_MR_OUT_B] & mr_low);
    end
  end

  // absent detectors/outputs on the reduced part are trusted to be zero

endmodule

// ### seq_output_sum_of_products_bench.sv
// ****************************************************************
// self-checking bench with a reference model of both outputs
// ****************************************************************
module seq_output_sum_of_products_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk, nrst, cfg_wr, cfg_rd;
  reg  [7:0]  cfg_addr, cfg_wdata, exp_rd_reg;
  reg  [24:0] c;
  reg  [7:0]  sh_reg [0:255];
  reg  [1:0]  pa, pb, exp_pa_reg, exp_pb_reg;
  reg         exp_a_reg, exp_b_reg;
  reg  [31:0] r;
  integer     n_errors, samples_checked, i, j;
  wire [7:0]  cfg_rdata;
  wire        seq_out_3, seq_out_4;
  wire [1:0]  out_a_products, out_b_products;

  seq_output_sum_of_products dut_u (
    .clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .volt_primary_ok(c[5:0]),
    .volt_secondary_ok(c[11:6]), .watchdog_timer_1(c[12]), .watchdog_timer_2(c[13]),
    .logic_input_1(c[14]), .logic_input_2(c[15]), .logic_input_3(c[16]),
    .logic_input_4(c[17]), .seq_out_1(c[18]), .seq_out_2(c[19]), .seq_out_5(c[20]),
    .seq_out_6(c[21]), .seq_out_7(c[22]), .seq_out_8(c[23]), .manual_reset_n(c[24]),
    .seq_out_3(seq_out_3), .seq_out_4(seq_out_4), .out_a_products(out_a_products),
    .out_b_products(out_b_products));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one product: each selected condition must be healthy, x is the other output
  function pr(input [7:0] b, input [7:0] e, input k, input x);
    pr = (&(~sh_reg[b] | {~c[13], ~c[12], c[5:0]}))
       & (&(~sh_reg[b + 1] | {~c[15], ~c[14], c[11:6]}))
       & (&(~sh_reg[b + 2] | {~c[22:20], ~x, ~c[19:18], ~c[17:16]}))
       & ~(sh_reg[e][k] & c[23]);
  endfunction
  // reduced part: detectors 5-6 and outputs 1, 2 and 8 stay deselected
  function [7:0] reduced_mask(input [7:0] a);
    reg [7:0] k;
    begin
      k = a - 8'h16;
      k = (k > 8'h06) ? k - 8'h07 : k;
      if (a < 8'h16 || a > 8'h23)
        reduced_mask = 8'hff;
      else if (k == 8'h02 || k == 8'h05)
        reduced_mask = 8'hf3;
      else if (k == 8'h06)
        reduced_mask = 8'hfc;
      else
        reduced_mask = 8'hcf;
    end
  endfunction

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // reference model; cross terms use last cycle's outputs, as the design does
  always @(posedge clk) begin
    pa = {pr(8'h19, 8'h1c, 1'b1, exp_b_reg), pr(8'h16, 8'h1c, 1'b0, exp_b_reg)};
    pb = {pr(8'h20, 8'h23, 1'b1, exp_a_reg), pr(8'h1d, 8'h23, 1'b0, exp_a_reg)};
    exp_pa_reg <= nrst ? pa : 2'h0;
    exp_pb_reg <= nrst ? pb : 2'h0;
    exp_a_reg <= nrst & (~|pa | (sh_reg[8'h40][2] & ~c[24]));
    exp_b_reg <= nrst & (~|pb | (sh_reg[8'h40][3] & ~c[24]));
    if (!nrst || cfg_rd)
      exp_rd_reg <= nrst ? sh_reg[cfg_addr] : 8'h00;
    // own loop index, so the stimulus counter is never disturbed
    if (!nrst)
      for (j = 0; j < 256; j = j + 1)
        sh_reg[j] <= 8'h00;
    if (nrst && cfg_wr && ((cfg_addr >= 8'h16 && cfg_addr <= 8'h23) || cfg_addr == 8'h40))
      sh_reg[cfg_addr] <= cfg_wdata;
  end

  task check(input [7:0] seen, input [7:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // compare once the edge's updates have landed, before new stimulus
  always @(posedge clk) begin
    #1;
    check({6'h00, seq_out_4, seq_out_3}, {6'h00, exp_b_reg, exp_a_reg});
    check({4'h0, out_b_products, out_a_products}, {4'h0, exp_pb_reg, exp_pa_reg});
    check(cfg_rdata, exp_rd_reg);
  end

  task conclude;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #160000;
    n_errors = n_errors + 1;
    conclude;
  end

  // stimulus: byte readback first, then random traffic with a reset inside
  initial begin
    {nrst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 19'h0;
    c = 25'h100_0fff;
    r = 32'h10a9_baf3;
    n_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    #2 nrst = 1;
    for (i = 0; i < 16; i = i + 1) begin
      r = lfsr(r);
      @(posedge clk);
      #2 cfg_wr = 1;
      cfg_rd = 0;
      cfg_addr = (i < 14) ? 8'h16 + i[7:0] : ((i == 14) ? 8'h40 : 8'h90);
      cfg_wdata = r[7:0];
      @(posedge clk);
      #2 cfg_wr = 0;
      cfg_rd = 1;
    end
    // healthy-biased flags and sparse selections so both product values occur
    // after the mid-run reset the software of the reduced part is played
    for (i = 0; i < 2000; i = i + 1) begin
      @(posedge clk);
      #2 nrst = (i < 1000 || i > 1002);
      r = lfsr(r);
      c = r[24:0];
      r = lfsr(r);
      c = {c[24] | r[24], c[23:12] & r[23:12], c[11:0] | r[11:0]};
      r = lfsr(r);
      cfg_wr = (r[31:30] == 2'b00);
      cfg_rd = r[29];
      cfg_addr = (r[28:25] == 4'hf) ? r[24:17] : ((r[28:25] == 4'he) ? 8'h40 : 8'h16 + r[28:25]);
      cfg_wdata = r[7:0] & r[15:8] & ((i > 1002) ? reduced_mask(cfg_addr) : 8'hff);
    end
    conclude;
  end
endmodule

// ### sop_check_sva.sv
// ****************************************************************
// port-level checks for the output dependency block
// ****************************************************************
module sop_check (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       manual_reset_n,
  input wire logic       seq_out_3,
  input wire logic       seq_out_4,
  input wire logic [1:0] out_a_products,
  input wire logic [1:0] out_b_products
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // decode of the byte bank, kept apart from the design's own decode
  wire mapped = (cfg_addr >= 8'h16 && cfg_addr <= 8'h23) || cfg_addr == 8'h40;
  // write a byte, then read the same byte on the very next cycle
  sequence s_wr_then_rd;
    cfg_wr && !cfg_rd && mapped ##1 cfg_rd && !cfg_wr && $stable(cfg_addr);
  endsequence
  // products and outputs share one edge, so the past input is the cause
  a_out_a_follows: assert property (|out_a_products && $past(manual_reset_n) |-> !seq_out_3)
    else $error("output a asserted with a product true");
  a_out_a_asserts: assert property (out_a_products == 2'b00 && $past(nrst) |-> seq_out_3)
    else $error("output a deasserted with both products false");
  a_out_b_follows: assert property (|out_b_products && $past(manual_reset_n) |-> !seq_out_4)
    else $error("output b asserted with a product true");
  a_out_b_asserts: assert property (out_b_products == 2'b00 && $past(nrst) |-> seq_out_4)
    else $error("output b deasserted with both products false");
  // an empty selection leaves nothing to fail, so every product is one
  a_empty_cfg: assert property ($rose(nrst) |=> out_a_products == 2'b11 && out_b_products == 2'b11)
    else $error("products not one with cleared selections");
  a_rd_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  a_rd_unmapped: assert property (cfg_rd && !mapped |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_wr_readback: assert property (s_wr_then_rd |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("read back differs from byte written");
endmodule

bind seq_output_sum_of_products sop_check chk_u (
  .clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .manual_reset_n(manual_reset_n),
  .seq_out_3(seq_out_3), .seq_out_4(seq_out_4), .out_a_products(out_a_products),
  .out_b_products(out_b_products)
);

// ### sop_defines.vh
`ifndef SOP_DEFINES_VH
`define SOP_DEFINES_VH

// ****************************************************************
// configuration byte offsets
// ****************************************************************
`define OFS_A_P1_PRIMARY   8'h16
`define OFS_A_P1_SECONDARY 8'h17
`define OFS_A_P1_OUTPUT    8'h18
`define OFS_A_P2_PRIMARY   8'h19
`define OFS_A_P2_SECONDARY 8'h1a
`define OFS_A_P2_OUTPUT    8'h1b
`define OFS_A_EIGHTH       8'h1c
`define OFS_B_P1_PRIMARY   8'h1d
`define OFS_B_P1_SECONDARY 8'h1e
`define OFS_B_P1_OUTPUT    8'h1f
`define OFS_B_P2_PRIMARY   8'h20
`define OFS_B_P2_SECONDARY 8'h21
`define OFS_B_P2_OUTPUT    8'h22
`define OFS_B_EIGHTH       8'h23
`define OFS_MR_DEPEND      8'h40

// ****************************************************************
// bank layout and field positions
// ****************************************************************
`define BANK_FIRST         8'h16
`define BANK_LAST          8'h23
`define BANK_MR_INDEX      4'he
`define BANK_DEPTH         15
`define CFG_RESET          8'h00
`define BIT_P1_EIGHTH      0
`define BIT_P2_EIGHTH      1
`define BIT_MR_OUT_A       2
`define BIT_MR_OUT_B       3

`endif
